// *** design/tmc_pkg.sv ***
package tmc_pkg;
	// ****************************************
	// Special function register map
	// ****************************************
	localparam logic [7:0] TMC_ADDR_RUN_CONTROL = 8'h88;
	localparam logic [7:0] TMC_ADDR_MODE_SELECT = 8'h89;
	localparam logic [7:0] TMC_ADDR_A_LOW = 8'h8a;
	localparam logic [7:0] TMC_ADDR_B_LOW = 8'h8b;
	localparam logic [7:0] TMC_ADDR_A_HIGH = 8'h8c;
	localparam logic [7:0] TMC_ADDR_B_HIGH = 8'h8d;
	localparam logic [7:0] TMC_RUN_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TMC_MODE_SELECT_RESET = 8'h00;
	localparam logic [7:0] TMC_COUNT_RESET = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int TMC_BIT_B_FLAG = 7;
	localparam int TMC_BIT_B_RUN = 6;
	localparam int TMC_BIT_A_FLAG = 5;
	localparam int TMC_BIT_A_RUN = 4;
	localparam int TMC_BIT_B_GATE = 7;
	localparam int TMC_BIT_B_SRC = 6;
	localparam int TMC_POS_B_MODE = 4;
	localparam int TMC_BIT_A_GATE = 3;
	localparam int TMC_BIT_A_SRC = 2;
	localparam int TMC_POS_A_MODE = 0;
	localparam logic [4:0] TMC_PRESCALE_MAX = 5'h1f;

	typedef enum logic [1:0]
	{
		TMC_MODE_PRESCALED = 2'b00,
		TMC_MODE_SIXTEEN = 2'b01,
		TMC_MODE_RELOAD = 2'b10,
		TMC_MODE_SPLIT = 2'b11
	} tmc_mode_type;

	// Per-timer controls as decoded from the mode and run registers
	typedef struct packed
	{
		logic gate;
		logic src_ext;
		tmc_mode_type mode;
		logic run;
	} tmc_ctrl_type;

	// Core-side register access strobe bundle
	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmc_sfr_type;
endpackage

// *** design/tmc_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser with a registered falling-edge detect after it
module tmc_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin in, synchronised level and edge out
	input wire logic pin,
	output logic level,
	output logic fall
);
	import tmc_pkg::*;
	logic meta_reg;
	logic level_reg;
	logic prev_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= 1'b0;
			level_reg <= 1'b0;
			prev_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= pin;
			level_reg <= meta_reg;
			prev_reg <= level_reg;
		end
	end

	assign level = level_reg;
	// High sample followed by low sample
	assign fall = prev_reg & ~level_reg;
endmodule // tmc_sync

// *** design/tmc_ctr8.sv ***
`timescale 1ns/1ps
// One byte count stage: increment, wrap detect, load and reload
module tmc_ctr8 #(
	parameter int WIDTH = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic inc,
	input wire logic [WIDTH-1:0] wrap_at,
	input wire logic reload,
	input wire logic [WIDTH-1:0] reload_val,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_val,
	// State
	output logic [WIDTH-1:0] count,
	output logic wrap
);
	import tmc_pkg::*;
	logic [WIDTH-1:0] count_reg;

	// Wrap from the stage's wrap_at value to zero, or to reload_val when reload is set
	assign wrap = inc && (count_reg == wrap_at);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			count_reg <= WIDTH'(TMC_COUNT_RESET);
		else if (load)
			count_reg <= load_val;
		else if (wrap && reload)
			count_reg <= reload_val;
		else if (wrap)
			count_reg <= '0;
		else if (inc)
			count_reg <= count_reg + WIDTH'(1);
	end

	assign count = count_reg;
endmodule // tmc_ctr8

// *** design/tmc_top.sv ***
`timescale 1ns/1ps
module tmc_top
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic SYS_RST,
	// Special function register bus
	input wire tmc_pkg::tmc_sfr_type SFR_IN,
	output logic [7:0] SFR_RDATA,
	// Interrupt vector acknowledges
	input wire logic VECTOR_A_ACK,
	input wire logic VECTOR_B_ACK,
	// External pins
	input wire logic EXT_IRQ_A_PIN,
	input wire logic EXT_IRQ_B_PIN,
	input wire logic TIMER_A_COUNT_PIN,
	input wire logic TIMER_B_COUNT_PIN,
	// Status
	output logic TIMER_A_OVERFLOW_FLAG,
	output logic TIMER_B_OVERFLOW_FLAG
);
	import tmc_pkg::*;

	// ****************************************
	// Registers and decode
	// ****************************************
	logic [7:0] timer_mode_select_reg;
	logic timer_a_run_reg;
	logic timer_b_run_reg;
	logic flag_a_reg;
	logic flag_b_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	tmc_ctrl_type ctrl_a;
	tmc_ctrl_type ctrl_b;
	logic wr_run;
	logic wr_mode;

	assign wr_run = SFR_IN.wr && (SFR_IN.addr == TMC_ADDR_RUN_CONTROL);
	assign wr_mode = SFR_IN.wr && (SFR_IN.addr == TMC_ADDR_MODE_SELECT);

	always_comb
	begin
		ctrl_a.gate = timer_mode_select_reg[TMC_BIT_A_GATE];
		ctrl_a.src_ext = timer_mode_select_reg[TMC_BIT_A_SRC];
		ctrl_a.mode = tmc_mode_type'(
			timer_mode_select_reg[TMC_POS_A_MODE +: 2]);
		ctrl_a.run = timer_a_run_reg;
		ctrl_b.gate = timer_mode_select_reg[TMC_BIT_B_GATE];
		ctrl_b.src_ext = timer_mode_select_reg[TMC_BIT_B_SRC];
		ctrl_b.mode = tmc_mode_type'(
			timer_mode_select_reg[TMC_POS_B_MODE +: 2]);
		ctrl_b.run = timer_b_run_reg;
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			timer_mode_select_reg <= TMC_MODE_SELECT_RESET;
		else if (wr_mode)
			timer_mode_select_reg <= SFR_IN.wdata;
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			timer_a_run_reg <= TMC_RUN_CONTROL_RESET[TMC_BIT_A_RUN];
			timer_b_run_reg <= TMC_RUN_CONTROL_RESET[TMC_BIT_B_RUN];
		end
		else if (wr_run)
		begin
			timer_a_run_reg <= SFR_IN.wdata[TMC_BIT_A_RUN];
			timer_b_run_reg <= SFR_IN.wdata[TMC_BIT_B_RUN];
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic irq_a_lvl;
	logic irq_b_lvl;
	logic cnt_a_fall;
	logic cnt_b_fall;

	tmc_sync u_sync_irq_a (.clk(MCLK), .rst(SYS_RST),
		.pin(EXT_IRQ_A_PIN), .level(irq_a_lvl), .fall());
	tmc_sync u_sync_irq_b (.clk(MCLK), .rst(SYS_RST),
		.pin(EXT_IRQ_B_PIN), .level(irq_b_lvl), .fall());
	tmc_sync u_sync_cnt_a (.clk(MCLK), .rst(SYS_RST),
		.pin(TIMER_A_COUNT_PIN), .level(), .fall(cnt_a_fall));
	tmc_sync u_sync_cnt_b (.clk(MCLK), .rst(SYS_RST),
		.pin(TIMER_B_COUNT_PIN), .level(), .fall(cnt_b_fall));

	// ****************************************
	// Enable and count events
	// ****************************************
	logic en_a;
	logic en_b;
	logic tick_a;
	logic tick_b;

	assign en_a = ctrl_a.run && (!ctrl_a.gate || irq_a_lvl);
	assign en_b = ctrl_b.run && (!ctrl_b.gate || irq_b_lvl);
	// Pin edge or one tick per core clock
	assign tick_a = en_a && (ctrl_a.src_ext ? cnt_a_fall : 1'b1);
	assign tick_b = en_b && (ctrl_b.src_ext ? cnt_b_fall : 1'b1);

	// ****************************************
	// Count stages
	// ****************************************
	logic [7:0] al;
	logic [7:0] ah;
	logic [7:0] bl;
	logic [7:0] bh;
	logic al_wrap;
	logic ah_wrap;
	logic bl_wrap;
	logic bh_wrap;
	logic al_inc;
	logic ah_inc;
	logic bl_inc;
	logic bh_inc;
	logic [7:0] al_top;
	logic [7:0] bl_top;
	logic a_split;
	logic ld_al;
	logic ld_ah;
	logic ld_bl;
	logic ld_bh;

	assign a_split = (ctrl_a.mode == TMC_MODE_SPLIT);
	// Low byte acts as 5-bit prescaler in mode 00
	assign al_top = (ctrl_a.mode == TMC_MODE_PRESCALED) ?
		{3'h0, TMC_PRESCALE_MAX} : 8'hff;
	assign bl_top = (ctrl_b.mode == TMC_MODE_PRESCALED) ?
		{3'h0, TMC_PRESCALE_MAX} : 8'hff;
	assign al_inc = tick_a;
	assign ah_inc = a_split ? timer_b_run_reg :
		(ctrl_a.mode == TMC_MODE_RELOAD) ? 1'b0 :
		al_wrap;
	// Timer B halts entirely in its mode 11
	assign bl_inc = tick_b && (ctrl_b.mode != TMC_MODE_SPLIT);
	assign bh_inc = (ctrl_b.mode == TMC_MODE_RELOAD) ? 1'b0 :
		bl_wrap;
	assign ld_al = SFR_IN.wr && (SFR_IN.addr == TMC_ADDR_A_LOW);
	assign ld_ah = SFR_IN.wr && (SFR_IN.addr == TMC_ADDR_A_HIGH);
	assign ld_bl = SFR_IN.wr && (SFR_IN.addr == TMC_ADDR_B_LOW);
	assign ld_bh = SFR_IN.wr && (SFR_IN.addr == TMC_ADDR_B_HIGH);

	tmc_ctr8 #(.WIDTH(8)) u_al (.clk(MCLK), .rst(SYS_RST),
		.inc(al_inc), .wrap_at(al_top),
		.reload(ctrl_a.mode == TMC_MODE_RELOAD), .reload_val(ah),
		.load(ld_al), .load_val(SFR_IN.wdata),
		.count(al), .wrap(al_wrap));
	tmc_ctr8 #(.WIDTH(8)) u_ah (.clk(MCLK), .rst(SYS_RST),
		.inc(ah_inc), .wrap_at(8'hff),
		.reload(1'b0), .reload_val(8'h00),
		.load(ld_ah), .load_val(SFR_IN.wdata),
		.count(ah), .wrap(ah_wrap));
	tmc_ctr8 #(.WIDTH(8)) u_bl (.clk(MCLK), .rst(SYS_RST),
		.inc(bl_inc), .wrap_at(bl_top),
		.reload(ctrl_b.mode == TMC_MODE_RELOAD), .reload_val(bh),
		.load(ld_bl), .load_val(SFR_IN.wdata),
		.count(bl), .wrap(bl_wrap));
	tmc_ctr8 #(.WIDTH(8)) u_bh (.clk(MCLK), .rst(SYS_RST),
		.inc(bh_inc), .wrap_at(8'hff),
		.reload(1'b0), .reload_val(8'h00),
		.load(ld_bh), .load_val(SFR_IN.wdata),
		.count(bh), .wrap(bh_wrap));

	// ****************************************
	// Overflow flags
	// ****************************************
	logic ovf_a;
	logic ovf_b;

	// Reload mode: the low byte is the whole counter
	assign ovf_a = a_split ? al_wrap :
		(ctrl_a.mode == TMC_MODE_RELOAD) ? al_wrap : ah_wrap;
	assign ovf_b = a_split ? ah_wrap :
		(ctrl_b.mode == TMC_MODE_RELOAD) ? bl_wrap : bh_wrap;

	// Hardware set wins over a clear in the same cycle
	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			flag_a_reg <= TMC_RUN_CONTROL_RESET[TMC_BIT_A_FLAG];
			flag_b_reg <= TMC_RUN_CONTROL_RESET[TMC_BIT_B_FLAG];
		end
		else
		begin
			if (ovf_a)
				flag_a_reg <= 1'b1;
			else if (VECTOR_A_ACK)
				flag_a_reg <= 1'b0;
			else if (wr_run)
				flag_a_reg <= SFR_IN.wdata[TMC_BIT_A_FLAG];
			if (ovf_b)
				flag_b_reg <= 1'b1;
			else if (VECTOR_B_ACK)
				flag_b_reg <= 1'b0;
			else if (wr_run)
				flag_b_reg <= SFR_IN.wdata[TMC_BIT_B_FLAG];
		end
	end

	assign TIMER_A_OVERFLOW_FLAG = flag_a_reg;
	assign TIMER_B_OVERFLOW_FLAG = flag_b_reg;

	// ****************************************
	// Read data
	// ****************************************
	always_comb
	begin
		rdata_next = 8'h00;
		if (SFR_IN.rd)
		begin
			unique case (SFR_IN.addr)
				TMC_ADDR_RUN_CONTROL:
				begin
					rdata_next[TMC_BIT_B_FLAG] = flag_b_reg;
					rdata_next[TMC_BIT_B_RUN] = timer_b_run_reg;
					rdata_next[TMC_BIT_A_FLAG] = flag_a_reg;
					rdata_next[TMC_BIT_A_RUN] = timer_a_run_reg;
				end
				TMC_ADDR_MODE_SELECT: rdata_next = timer_mode_select_reg;
				TMC_ADDR_A_LOW: rdata_next = al;
				TMC_ADDR_A_HIGH: rdata_next = ah;
				TMC_ADDR_B_LOW: rdata_next = bl;
				TMC_ADDR_B_HIGH: rdata_next = bh;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge SYS_RST)
	begin
		if (SYS_RST)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	assign SFR_RDATA = rdata_reg;

	// ****************************************
	// Checks
	// ****************************************
	a_flag_a_set: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		ovf_a |=> flag_a_reg)
		else $error("timer A flag not set after overflow");
	a_flag_b_set: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(a_split && ah_wrap) |=> flag_b_reg)
		else $error("split high wrap did not set timer B flag");
	a_gate_b_hold: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_b.gate && !irq_b_lvl && !ld_bl) |=> $stable(bl))
		else $error("gated timer B advanced with pin low");
	a_run_b_count: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(timer_b_run_reg && !ctrl_b.gate && !ctrl_b.src_ext
		&& ctrl_b.mode == TMC_MODE_SIXTEEN && !ld_bl && bl != 8'hff)
		|=> bl == $past(bl) + 8'h01)
		else $error("ungated timer B failed to count");
	a_stop_b_hold: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_b.mode == TMC_MODE_SPLIT && !ld_bl && !ld_bh)
		|=> $stable(bl) && $stable(bh))
		else $error("timer B changed in stop mode");
	a_reload_a_low: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_a.mode == TMC_MODE_RELOAD && al_wrap && !ld_al && !ld_ah)
		|=> al == $past(ah))
		else $error("timer A low byte not reloaded");
	a_prescale_a: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_a.mode == TMC_MODE_PRESCALED && !ld_al && al <= 8'h1f)
		|=> al <= 8'h1f)
		else $error("timer A prescaler left five bits");
	a_ext_a_edge: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_a.src_ext && !cnt_a_fall && !ld_al) |=> $stable(al))
		else $error("timer A counted without pin edge");
	a_split_high: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(a_split && !timer_b_run_reg && !ld_ah) |=> $stable(ah))
		else $error("split high byte ran with timer B run clear");
	a_flag_b_ovf: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		ovf_b |=> flag_b_reg)
		else $error("timer B flag not set after overflow");
	a_ack_a_clear: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(VECTOR_A_ACK && !ovf_a) |=> !flag_a_reg)
		else $error("timer A flag not cleared by vector");
	a_gate_a_hold: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_a.gate && !irq_a_lvl && !ld_al) |=> $stable(al))
		else $error("gated timer A advanced with pin low");
	a_ext_b_edge: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_b.src_ext && !cnt_b_fall && !ld_bl) |=> $stable(bl))
		else $error("timer B counted without pin edge");
	a_reload_b_low: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_b.mode == TMC_MODE_RELOAD && bl_wrap && !ld_bl && !ld_bh)
		|=> bl == $past(bh))
		else $error("timer B low byte not reloaded");
	a_prescale_b: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_b.mode == TMC_MODE_PRESCALED && !ld_bl && bl <= 8'h1f)
		|=> bl <= 8'h1f)
		else $error("timer B prescaler left five bits");
	a_run_a_count: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(timer_a_run_reg && !ctrl_a.gate && !ctrl_a.src_ext
		&& ctrl_a.mode == TMC_MODE_SIXTEEN && !ld_al && al != 8'hff)
		|=> al == $past(al) + 8'h01)
		else $error("ungated timer A failed to count");
	a_cascade_a: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_a.mode == TMC_MODE_SIXTEEN && al_wrap && !ld_ah)
		|=> ah == $past(ah) + 8'h01)
		else $error("timer A high byte missed low wrap");
	a_cascade_b: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(ctrl_b.mode == TMC_MODE_SIXTEEN && bl_wrap && !ld_bh)
		|=> bh == $past(bh) + 8'h01)
		else $error("timer B high byte missed low wrap");
	a_run_off_hold: assert property (
		@(posedge MCLK) disable iff (SYS_RST)
		(!timer_a_run_reg && !ld_al) |=> $stable(al))
		else $error("timer A advanced with run clear");
endmodule // tmc_top

// *** test/tmc_core_model.sv ***
`timescale 1ns/1ps
module tmc_core_model
(
	// Clock
	input wire logic clk,
	// Register bus and vector acknowledges, index 1 is timer B
	output tmc_pkg::tmc_sfr_type sfr,
	output logic [1:0] ack,
	// Gate and count pins, index 1 is timer B
	output logic [1:0] gate_pin,
	output logic [1:0] cnt_pin
);
	import tmc_pkg::*;

	initial
	begin
		sfr = '0;
		ack = 2'b00;
		gate_pin = 2'b00;
		cnt_pin = 2'b00;
	end

	// ****************************************
	// Bus and pin tasks
	// ****************************************
	// One access cycle, then the bus goes idle for a cycle
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge clk);
		sfr <= '{wr: w, rd: ~w, addr: a, wdata: d};
		@(negedge clk);
		sfr <= '0;
	endtask

	task automatic set_gate(input int t, input logic g);
		@(negedge clk);
		gate_pin[t] <= g;
	endtask

	// Idle cycles; the first 4*p carry two-high two-low pulses on pin t
	task automatic idle(input int t, input int n, input int p);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk);
			cnt_pin[t] <= (i < 4 * p) && (i % 4 < 2);
		end
	endtask

	task automatic pulse_ack();
		@(negedge clk);
		ack <= 2'b11;
		@(negedge clk);
		ack <= 2'b00;
	endtask
endmodule // tmc_core_model

// *** test/tb_tmc_top.sv ***
`timescale 1ns/1ps
module tb_tmc_top;
	import tmc_pkg::*;
	logic MCLK;
	logic SYS_RST;
	tmc_sfr_type SFR_IN;
	logic [7:0] SFR_RDATA;
	logic [1:0] ack;
	logic [1:0] gate_pin;
	logic [1:0] cnt_pin;
	logic [1:0] flag;
	logic [7:0] exp_q[$];
	logic rd_d;
	logic [31:0] r;
	int err_count;
	int cmp_count;

	tmc_top tmc_top_inst (.MCLK(MCLK), .SYS_RST(SYS_RST), .SFR_IN(SFR_IN),
		.SFR_RDATA(SFR_RDATA), .VECTOR_A_ACK(ack[0]),
		.VECTOR_B_ACK(ack[1]), .EXT_IRQ_A_PIN(gate_pin[0]),
		.EXT_IRQ_B_PIN(gate_pin[1]), .TIMER_A_COUNT_PIN(cnt_pin[0]),
		.TIMER_B_COUNT_PIN(cnt_pin[1]), .TIMER_A_OVERFLOW_FLAG(flag[0]),
		.TIMER_B_OVERFLOW_FLAG(flag[1]));

	tmc_core_model tmc_core_model_inst (.clk(MCLK), .sfr(SFR_IN),
		.ack(ack), .gate_pin(gate_pin), .cnt_pin(cnt_pin));

	initial
	begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end

	// ****************************************
	// Checking
	// ****************************************
	task automatic chk(input string name, input logic [7:0] e,
		input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Read data stands one cycle after the read edge
	always @(posedge MCLK)
		rd_d <= SFR_IN.rd;

	always @(negedge MCLK)
		if (rd_d === 1'b1)
			chk("read data", exp_q.pop_front(), SFR_RDATA);

	// ****************************************
	// Stimulus
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tmc_core_model_inst.access(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		tmc_core_model_inst.access(1'b0, a, 8'h00);
	endtask

	// Counts run k+8 core cycles; flags must show after k of them
	task automatic rc(input int t, input logic [3:0] cfg,
		input logic [7:0] rv, input logic [15:0] st, input int k,
		input int p, input logic g, input logic [15:0] ex,
		input logic [1:0] fl);
		tmc_core_model_inst.set_gate(t, g);
		wr(TMC_ADDR_MODE_SELECT, t ? {cfg, 4'h0} : {4'h0, cfg});
		wr(TMC_ADDR_A_LOW + 8'(t), st[7:0]);
		wr(TMC_ADDR_A_HIGH + 8'(t), st[15:8]);
		wr(TMC_ADDR_RUN_CONTROL, rv);
		tmc_core_model_inst.idle(t, k, p);
		chk("flag pins", {6'h00, fl}, {6'h00, flag});
		rd(TMC_ADDR_RUN_CONTROL, rv | {fl[1], 1'b0, fl[0], 5'h00});
		tmc_core_model_inst.pulse_ack();
		rd(TMC_ADDR_RUN_CONTROL, rv);
		wr(TMC_ADDR_RUN_CONTROL, 8'h00);
		rd(TMC_ADDR_A_LOW + 8'(t), ex[7:0]);
		rd(TMC_ADDR_A_HIGH + 8'(t), ex[15:8]);
		$display("case timer %0d config %h done", t, cfg);
	endtask

	task automatic per_timer(input int t);
		logic [1:0] f;
		logic [7:0] rb;
		logic [15:0] st;
		f = t ? 2'b10 : 2'b01;
		rb = t ? 8'h40 : 8'h10;
		r = $urandom;
		st = 16'hfff0 | {12'h000, r[3:0]};
		rc(t,4'h1,rb,st,20,0,0,st+16'd28,f);
		rc(t,4'h2,rb,16'hf0fe,4,0,0,16'hf0fa,f);
		rc(t,4'h0,rb,16'hff1e,4,0,0,16'h000a,f);
		rc(t,4'h9,rb,16'h0010,4,0,0,16'h0010,2'b00);
		rc(t,4'h9,rb,16'h0010,4,0,1,16'h001c,2'b00);
		rc(t,4'h5,rb,16'h0000,16,3,0,16'h0003,2'b00);
	endtask

	initial
	begin
		SYS_RST = 1'b1;
		err_count = 0;
		cmp_count = 0;
		void'($urandom(76));
		repeat (6) @(posedge MCLK);
		@(negedge MCLK);
		SYS_RST = 1'b0;
		for (int a = 8'h88; a <= 8'h90; a++)
			rd(8'(a), 8'h00);
		wr(TMC_ADDR_MODE_SELECT, 8'ha5);
		rd(TMC_ADDR_MODE_SELECT, 8'ha5);
		wr(TMC_ADDR_RUN_CONTROL, 8'h0f);
		rd(TMC_ADDR_RUN_CONTROL, 8'h00);
		wr(8'h90, 8'hff);
		rd(8'h90, 8'h00);
		$display("register map test done");
		per_timer(0);
		per_timer(1);
		rc(1,4'h3,8'h40,16'h4433,4,0,0,16'h4433,2'b00);
		rc(0,4'h3,8'h50,16'hfefe,4,0,0,16'h0a0a,2'b11);
		repeat (4) @(negedge MCLK);
		chk("pending reads", 8'h00, 8'(exp_q.size()));
		print_verdict();
	end

	// Cuts a hang short
	initial
	begin
		repeat (20000) @(posedge MCLK);
		err_count++;
		$display("[ERR] run length expected end seen timeout");
		print_verdict();
	end
endmodule // tb_tmc_top
